/* rtl/acs_defines.svh */
// Constants of the converter sequencer: offsets, fields, resets, counts
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ==========================================================
// Register offsets
`define ACS_OFF_PRESCALE   8'hF2
`define ACS_OFF_CTRL       8'hF3
`define ACS_OFF_RES_LOW    8'hF4
`define ACS_OFF_RES_HIGH   8'hF5
`define ACS_OFF_PIN_SEL    8'hF6
`define ACS_OFF_CLK_CFG    8'hF7
`define ACS_OFF_RELOAD     8'hF8

// ==========================================================
// Control register fields
`define ACS_CTRL_QUIET     7
`define ACS_CTRL_PSEUDO    6
`define ACS_CTRL_ENABLE    5
`define ACS_CTRL_DONE      4
`define ACS_CTRL_START     3

// Clock configuration fields
`define ACS_CFG_X2         0
`define ACS_CFG_IRQ_EN     1

// ==========================================================
// Reset values
`define ACS_RST_CTRL       8'h00
`define ACS_RST_PRESCALE   7'h00
`define ACS_RST_PIN_SEL    8'h00
`define ACS_RST_RELOAD     8'h00
`define ACS_RST_RESULT     10'h000

// ==========================================================
// Timing counts
`define ACS_HOLD_PERIODS   4'd10
`define ACS_PRE_BASE       10'h200
`define ACS_PRS_ZERO_DIV   9'h100
`define ACS_SETTLE_NS      4000
`define ACS_CLK_NS         10

`endif

/* rtl/acs_pkg.sv */
// Types of the converter sequencer
`default_nettype none
package acs_pkg;

  // ========================================================
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_bus_req_t;

  // ========================================================
  // Control register layout
  typedef struct packed {
    logic       quiet;
    logic       pseudo;
    logic       enable;
    logic       done;
    logic       start;
    logic [2:0] chan;
  } acs_ctrl_t;

  // ========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ALIGN  = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_HOLD   = 4'b1000
  } acs_state_t;

endpackage
`default_nettype wire

/* rtl/acs_clk_div.sv */
// Pre-clock and conversion clock divider, one tick per period
`include "acs_defines.svh"
`default_nettype none
module acs_clk_div (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic       x2,
  input  wire logic [7:0] reload,
  input  wire logic [6:0] prescale,
  output var  logic       conv_tick
);
  logic [9:0] pre_cnt_r;
  logic [9:0] pre_div;
  logic       pre_tick;
  logic [8:0] conv_cnt_r;
  logic [8:0] conv_div;
  logic       conv_end;

  // ========================================================
  // Pre-clock divide
  // reload divide or bypass
  assign pre_div  = `ACS_PRE_BASE - {1'b0, reload, 1'b0};
  assign pre_tick = x2 | (pre_cnt_r == pre_div - 10'h001);

  always_ff @(posedge clk) begin
    if (!nrst || !run || pre_tick) begin
      pre_cnt_r <= 10'h000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
    end
  end

  // ========================================================
  // Conversion clock divide
  // twice prescaler, zero is 256
  assign conv_div = (prescale == 7'h00) ? `ACS_PRS_ZERO_DIV
                                        : {1'b0, prescale, 1'b0};
  assign conv_end = pre_tick && (conv_cnt_r == conv_div - 9'h001);

  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      conv_cnt_r <= 9'h000;
    end else if (conv_end) begin
      conv_cnt_r <= 9'h000;
    end else if (pre_tick) begin
      conv_cnt_r <= conv_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= run && conv_end;
    end
  end
endmodule
`default_nettype wire

/* rtl/acs_seq.sv */
// Converter sequencer: registers, sample/hold timing, approximation
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "acs_defines.svh"
`default_nettype none
module acs_seq (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire acs_pkg::acs_bus_req_t bus_req,
  output var  logic [7:0]           rdata,
  input  wire logic                 comp_above,
  output var  logic                 analog_en,
  output var  logic [2:0]           chan_out,
  output var  logic                 sample_sw,
  output var  logic                 hold_on,
  output var  logic [9:0]           dac_code,
  output var  logic [7:0]           pin_analog,
  output var  logic                 irq,
  output var  logic                 cpu_halt,
  output var  logic                 periph_stop,
  output var  logic                 irq_defer
);
  acs_pkg::acs_ctrl_t  ctrl_r;
  acs_pkg::acs_state_t state_r;
  logic [6:0]          prescale_r;
  logic [7:0]          pin_sel_r;
  logic [7:0]          reload_r;
  logic                x2_r;
  logic                irq_en_r;
  logic [9:0]          result_r;
  logic [9:0]          trial_r;
  logic [3:0]          bit_idx_r;
  logic [3:0]          hold_cnt_r;
  logic [9:0]          code_nxt;
  logic                conv_tick;
  logic                busy;
  logic                wr_ctrl;
  logic                launch;
  logic                finish;

  // ========================================================
  // Helpers
  function automatic logic [9:0] bit_mask(input logic [3:0] idx);
    bit_mask = 10'h001 << idx;
  endfunction

  function automatic logic hit(input acs_pkg::acs_bus_req_t req,
                               input logic [7:0]            off);
    hit = req.wr && (req.addr == off);
  endfunction

  assign busy    = ctrl_r.start;
  assign wr_ctrl = hit(bus_req, `ACS_OFF_CTRL);
  assign launch  = wr_ctrl && !busy && ctrl_r.enable
                   && bus_req.wdata[`ACS_CTRL_ENABLE]
                   && bus_req.wdata[`ACS_CTRL_START];
  assign code_nxt = comp_above ? trial_r
                               : (trial_r & ~bit_mask(bit_idx_r));
  assign finish  = (state_r == acs_pkg::ST_HOLD) && conv_tick
                   && (bit_idx_r == 4'h0);

  // ========================================================
  // Conversion clock
  acs_clk_div u_div (
    .clk       (clk),
    .nrst      (nrst),
    .run       (ctrl_r.enable),
    .x2        (x2_r),
    .reload    (reload_r),
    .prescale  (prescale_r),
    .conv_tick (conv_tick)
  );

  // ========================================================
  // Configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prescale_r <= `ACS_RST_PRESCALE;
      pin_sel_r  <= `ACS_RST_PIN_SEL;
      reload_r   <= `ACS_RST_RELOAD;
      x2_r       <= 1'b0;
      irq_en_r   <= 1'b0;
    end else begin
      if (hit(bus_req, `ACS_OFF_PRESCALE)) begin
        prescale_r <= bus_req.wdata[6:0];
      end
      if (hit(bus_req, `ACS_OFF_PIN_SEL)) begin
        pin_sel_r <= bus_req.wdata;
      end
      if (hit(bus_req, `ACS_OFF_RELOAD)) begin
        reload_r <= bus_req.wdata;
      end
      if (hit(bus_req, `ACS_OFF_CLK_CFG)) begin
        x2_r     <= bus_req.wdata[`ACS_CFG_X2];
        irq_en_r <= bus_req.wdata[`ACS_CFG_IRQ_EN];
      end
    end
  end

  // ========================================================
  // Control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= `ACS_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.enable <= bus_req.wdata[`ACS_CTRL_ENABLE];
        ctrl_r.done   <= bus_req.wdata[`ACS_CTRL_DONE];
        // channel and modes locked while busy, except that a write with enable low clears the modes
        if (!busy) begin
          ctrl_r.chan   <= bus_req.wdata[2:0];
          ctrl_r.quiet  <= bus_req.wdata[`ACS_CTRL_QUIET];
          ctrl_r.pseudo <= bus_req.wdata[`ACS_CTRL_PSEUDO];
        end
      end
      if (launch) begin
        ctrl_r.start <= 1'b1;
      end
      if (wr_ctrl && !bus_req.wdata[`ACS_CTRL_ENABLE]) begin
        ctrl_r.start  <= 1'b0;
        ctrl_r.quiet  <= 1'b0;
        ctrl_r.pseudo <= 1'b0;
      end
      if (finish) begin
        ctrl_r.start  <= 1'b0;
        ctrl_r.quiet  <= 1'b0;
        ctrl_r.pseudo <= 1'b0;
        ctrl_r.done   <= 1'b1;
      end
    end
  end

  // ========================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!nrst || !ctrl_r.enable) begin
      state_r    <= acs_pkg::ST_IDLE;
      trial_r    <= 10'h000;
      bit_idx_r  <= 4'h0;
      hold_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        acs_pkg::ST_IDLE: begin
          if (launch) begin
            state_r <= acs_pkg::ST_ALIGN;
          end
        end
        acs_pkg::ST_ALIGN: begin
          // wait for start of a full period
          if (conv_tick) begin
            state_r <= acs_pkg::ST_SAMPLE;
          end
        end
        acs_pkg::ST_SAMPLE: begin
          if (conv_tick) begin
            state_r    <= acs_pkg::ST_HOLD;
            trial_r    <= bit_mask(4'h9);
            bit_idx_r  <= 4'h9;
            hold_cnt_r <= 4'h0;
          end
        end
        acs_pkg::ST_HOLD: begin
          if (conv_tick) begin
            hold_cnt_r <= hold_cnt_r + 4'h1;
            if (bit_idx_r == 4'h0) begin
              state_r <= acs_pkg::ST_IDLE;
              trial_r <= code_nxt;
            end else begin
              trial_r   <= code_nxt | bit_mask(bit_idx_r - 4'h1);
              bit_idx_r <= bit_idx_r - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ========================================================
  // Result
  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_r <= `ACS_RST_RESULT;
    end else if (finish) begin
      result_r <= code_nxt;
    end
  end

  // ========================================================
  // Read port
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ACS_OFF_PRESCALE: rdata <= {1'b0, prescale_r};
        `ACS_OFF_CTRL:     rdata <= ctrl_r;
        `ACS_OFF_RES_LOW:  rdata <= {6'h00, result_r[1:0]};
        `ACS_OFF_RES_HIGH: rdata <= result_r[9:2];
        `ACS_OFF_PIN_SEL:  rdata <= pin_sel_r;
        `ACS_OFF_CLK_CFG:  rdata <= {6'h00, irq_en_r, x2_r};
        `ACS_OFF_RELOAD:   rdata <= reload_r;
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ========================================================
  // Analog and system outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_en   <= 1'b0;
      chan_out    <= 3'h0;
      sample_sw   <= 1'b0;
      hold_on     <= 1'b0;
      dac_code    <= 10'h000;
      pin_analog  <= 8'h00;
      irq         <= 1'b0;
      cpu_halt    <= 1'b0;
      periph_stop <= 1'b0;
      irq_defer   <= 1'b0;
    end else begin
      analog_en   <= ctrl_r.enable;
      chan_out    <= ctrl_r.chan;
      sample_sw   <= (state_r == acs_pkg::ST_SAMPLE);
      hold_on     <= (state_r == acs_pkg::ST_HOLD);
      dac_code    <= trial_r;
      pin_analog  <= pin_sel_r;
      // this request is the wake event
      irq         <= ctrl_r.done && irq_en_r;
      cpu_halt    <= busy && ctrl_r.pseudo;
      periph_stop <= busy && ctrl_r.quiet;
      irq_defer   <= busy && (ctrl_r.pseudo || ctrl_r.quiet);
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_start;
    launch;
  endsequence

  sequence s_busy_up;
    ##1 busy;
  endsequence

  property p_start;
    s_start |-> s_busy_up;
  endproperty
  a_start: assert property (p_start) else $error("start lost");

  property p_ignore;
    wr_ctrl && busy
      && bus_req.wdata[`ACS_CTRL_ENABLE] && !finish |=> busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy cleared");

  property p_sample;
    state_r == acs_pkg::ST_ALIGN && conv_tick && ctrl_r.enable
      |=> ##1 sample_sw;
  endproperty
  a_sample: assert property (p_sample) else $error("no sample");

  property p_hold_ten;
    finish |-> hold_cnt_r == `ACS_HOLD_PERIODS - 4'h1;
  endproperty
  a_hold_ten: assert property (p_hold_ten) else $error("hold count");

  property p_done;
    finish |=> ctrl_r.done && !busy && result_r == $past(code_nxt);
  endproperty
  a_done: assert property (p_done) else $error("completion");

  property p_done_keep;
    ctrl_r.done && !wr_ctrl |=> ctrl_r.done;
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done lost");

  property p_irq;
    ctrl_r.done && irq_en_r |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");

  property p_standby;
    !ctrl_r.enable |=> state_r == acs_pkg::ST_IDLE && !analog_en;
  endproperty
  a_standby: assert property (p_standby) else $error("not standby");

  property p_halt;
    busy && ctrl_r.pseudo |=> cpu_halt && irq_defer;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");

  property p_quiet;
    busy && ctrl_r.quiet |=> periph_stop;
  endproperty
  a_quiet: assert property (p_quiet) else $error("no quiet");

  property p_modes_clear;
    $fell(busy) |-> !ctrl_r.pseudo && !ctrl_r.quiet;
  endproperty
  a_modes_clear: assert property (p_modes_clear) else $error("modes");

  property p_result_keep;
    !finish |=> $stable(result_r);
  endproperty
  a_result_keep: assert property (p_result_keep) else $error("result");
endmodule
`default_nettype wire

/* test/acs_testbench.sv */
// Self-checking bench of the converter sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic                  clk;
  logic                  nrst;
  acs_pkg::acs_bus_req_t bus_req;
  logic [7:0]            rdata;
  logic                  comp_above;
  logic                  analog_en;
  logic [2:0]            chan_out;
  logic                  sample_sw;
  logic                  hold_on;
  logic [9:0]            dac_code;
  logic [7:0]            pin_analog;
  logic                  irq;
  logic                  cpu_halt;
  logic                  periph_stop;
  logic                  irq_defer;
  logic [9:0]            ain;
  logic [9:0]            last_v;
  logic [31:0]           rng;
  logic [7:0]            d;
  logic [7:0]            hi;
  int                    n_mismatch;
  int                    samples_checked;
  int                    n_samp;
  int                    n_hold;
  int                    n_cyc;

  // Clock configurations: x2, reload, prescale
  localparam logic [16:0] cfg_tab [5] = '{17'h1_0001, 17'h1_0003,
                                          17'h0_FF01, 17'h0_FE02,
                                          17'h1_0000};

  acs_seq dut_u (
    .clk         (clk),
    .nrst        (nrst),
    .bus_req     (bus_req),
    .rdata       (rdata),
    .comp_above  (comp_above),
    .analog_en   (analog_en),
    .chan_out    (chan_out),
    .sample_sw   (sample_sw),
    .hold_on     (hold_on),
    .dac_code    (dac_code),
    .pin_analog  (pin_analog),
    .irq         (irq),
    .cpu_halt    (cpu_halt),
    .periph_stop (periph_stop),
    .irq_defer   (irq_defer)
  );

  // Comparator of an ideal analog input
  assign comp_above = (ain >= dac_code);

  always #5 clk = ~clk;

  // ==========================================================
  // Period counters and timeout
  always @(posedge clk) begin
    n_cyc++;
    if (sample_sw === 1'b1) n_samp++;
    if (hold_on === 1'b1) n_hold++;
    if (n_cyc > 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic int period(input logic x2, input logic [7:0] rl,
                                input logic [6:0] ps);
    return (x2 ? 1 : 512 - 2 * int'(rl)) * (ps != 0 ? 2 * int'(ps) : 256);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic conv(input logic [7:0] mode, input logic [2:0] ch,
                      input logic [9:0] v, input logic ie, input int p);
    logic [7:0] c;
    logic [7:0] h;
    ain <= v;
    n_samp = 0;
    n_hold = 0;
    wr(8'hF3, mode | 8'h28 | {5'h00, ch});
    rd(8'hF3, c);
    check(c[3], 1'b1);
    check(chan_out, ch);
    check(cpu_halt, mode[6]);
    check(periph_stop, mode[7]);
    check(irq_defer, mode[6] | mode[7]);
    wr(8'hF3, 8'h28 | {5'h00, ~ch});
    @(posedge clk);
    #1;
    check(chan_out, ch);
    for (int i = 0; i < 3000 && c[3] !== 1'b0; i++) rd(8'hF3, c);
    check(c, {4'h3, 1'b0, ch});
    check(16'(n_samp), 16'(p));
    check(16'(n_hold), 16'(10 * p));
    rd(8'hF5, h);
    rd(8'hF4, c);
    check({h, c[1:0]}, v);
    check(irq, ie);
    check({cpu_halt, periph_stop, irq_defer}, 3'b000);
    last_v = v;
    wr(8'hF3, 8'h20 | {5'h00, ch});
    @(posedge clk);
    #1;
    check(irq, 1'b0);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    ain = 10'h000;
    rng = 32'h0000_001D;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(8'hF3, d);
    check(d, 8'h00);
    rd(8'hF5, d);
    check(d, 8'h00);
    rd(8'h00, d);
    check(d, 8'h00);
    check({analog_en, pin_analog}, 9'h000);
    wr(8'hF3, 8'h08);
    rd(8'hF3, d);
    check(d, 8'h00);
    rng = xs(rng);
    wr(8'hF6, rng[7:0]);
    rd(8'hF6, d);
    check(pin_analog, rng[7:0]);
    check(d, rng[7:0]);
    wr(8'hF3, 8'h20);
    repeat (400) @(posedge clk);
    check(analog_en, 1'b1);
    for (int k = 0; k < 5; k++) begin
      logic [16:0] cfg;
      cfg = cfg_tab[k];
      wr(8'hF7, {6'h00, k != 3, cfg[16]});
      wr(8'hF8, cfg[15:8]);
      wr(8'hF2, {1'b0, cfg[6:0]});
      rd(8'hF2, d);
      check(d, {1'b0, cfg[6:0]});
      rng = xs(rng);
      conv(k == 1 ? 8'h40 : (k == 2 ? 8'h80 : 8'h00), rng[2:0],
           k == 0 ? 10'h3FF : (k == 1 ? 10'h000 : rng[12:3]), k != 3,
           period(cfg[16], cfg[15:8], cfg[6:0]));
    end
    wr(8'hF2, 8'h01);
    wr(8'hF7, 8'h03);
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      conv(8'h00, 3'(i), rng[9:0], 1'b1, 2);
    end
    wr(8'hF2, 8'h00);
    wr(8'hF3, 8'h2D);
    repeat (50) @(posedge clk);
    wr(8'hF3, 8'h00);
    rd(8'hF3, d);
    check(d, 8'h05);
    check({analog_en, sample_sw, hold_on}, 3'b000);
    rd(8'hF5, hi);
    rd(8'hF4, d);
    check({hi, d[1:0]}, last_v);
    finish_test();
  end
endmodule
`default_nettype wire
